// file: src/caf_filter.sv
/*
  acceptance filter identifier register with its match logic, an AHB-Lite slave.
  assumes a single AHB-Lite master, word transfers, hclk at 100 MHz.
*/
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
//
// Summary of operation
// - standard pattern held in bits 15..5
// - pattern zero requires received bit zero
// - bits 4 and 2 read zero
// - mask enable, select one: extended only
// - mask enable, select zero: standard only
// - mask enable off: format ignored
// - extended pattern 17..16 in bits 1..0
`timescale 1ns/1ns
`default_nettype none
`include "caf_map.svh"
module caf_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic filter_hit
);
  import caf_pkg::*;

  // ****************************************
  // bus phase tracking
  // ****************************************
  caf_phase_e phase_r, phase_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic wr_r, wr_nxt;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    phase_nxt = phase_r;
    addr_nxt = addr_r;
    wr_nxt = wr_r;
    if (hready) begin
      phase_nxt = take ? CAF_DATA : CAF_IDLE;
      if (take) begin
        addr_nxt = haddr[7:0];
        wr_nxt = hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= CAF_IDLE;
      addr_r <= 8'h00;
      wr_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      addr_r <= addr_nxt;
      wr_r <= wr_nxt;
    end
  end

  // zero wait states; every response is OKAY, unmapped reads give zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // registers
  // ****************************************
  caf_filt_t filt_r, filt_nxt;
  logic mask_en_r, mask_en_nxt;
  logic [31:0] msg_r, msg_nxt;
  logic hit_r, hit_nxt;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic wr_now;
  logic hit_c;

  assign wr_now = (phase_r == CAF_DATA) && wr_r;

  always_comb begin
    filt_nxt = filt_r;
    mask_en_nxt = mask_en_r;
    msg_nxt = msg_r;
    if (wr_now) begin
      unique case (addr_r)
        `CAF_FILT_OFFS: filt_nxt = hwdata[15:0] & `CAF_FILT_WMASK;
        `CAF_CTRL_OFFS: mask_en_nxt = hwdata[0];
        `CAF_MSG_ID_OFFS: msg_nxt = hwdata;
        default: ;
      endcase
    end
    hit_nxt = hit_c;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `CAF_FILT_OFFS: rdata_nxt = {16'h0000, filt_nxt};
        `CAF_CTRL_OFFS: rdata_nxt = {31'h0000_0000, mask_en_nxt};
        `CAF_MSG_ID_OFFS: rdata_nxt = msg_nxt;
        `CAF_STAT_OFFS: rdata_nxt = {31'h0000_0000, hit_c};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r <= `CAF_FILT_RESET;
      mask_en_r <= 1'b0;
      msg_r <= 32'h0000_0000;
      hit_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      filt_r <= filt_nxt;
      mask_en_r <= mask_en_nxt;
      msg_r <= msg_nxt;
      hit_r <= hit_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign filter_hit = hit_r;

  // ****************************************
  // comparator
  // ****************************************
  caf_match u_match (
    .std_id_pattern(filt_r[`CAF_STD_HI:`CAF_STD_LO]),
    .ext_id_pattern(filt_r[`CAF_EXT_HI:`CAF_EXT_LO]),
    .id_format_select(filt_r[`CAF_FMT_BIT]),
    .id_format_mask_enable(mask_en_r),
    .msg_std_id(msg_r[`CAF_MSG_STD_HI:`CAF_MSG_STD_LO]),
    .msg_ext_id(msg_r[`CAF_MSG_EXT_HI:`CAF_MSG_EXT_LO]),
    .msg_is_ext(msg_r[`CAF_MSG_XTD_BIT]),
    .hit(hit_c)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_std_mismatch;
    @(posedge hclk) disable iff (!hresetn)
    (filt_r[15:5] != msg_r[28:18]) |=> !filter_hit;
  endproperty
  a_std_mismatch: assert property (p_std_mismatch)
    else $error("standard id mismatch yet hit");

  property p_std_zero;
    @(posedge hclk) disable iff (!hresetn)
    (filt_r[15:5] == 11'h000 && msg_r[28:18] != 11'h000) |=> !filter_hit;
  endproperty
  a_std_zero: assert property (p_std_zero)
    else $error("zero pattern matched nonzero id");

  property p_unimpl;
    @(posedge hclk) disable iff (!hresetn)
    (filt_r[4] == 1'b0) && (filt_r[2] == 1'b0);
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented filter bit set");

  property p_ext_only;
    @(posedge hclk) disable iff (!hresetn)
    (mask_en_r && filt_r[3] && !msg_r[31]) |=> !filter_hit;
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("standard frame passed extended-only filter");

  property p_std_only;
    @(posedge hclk) disable iff (!hresetn)
    (mask_en_r && !filt_r[3] && msg_r[31]) |=> !filter_hit;
  endproperty
  a_std_only: assert property (p_std_only)
    else $error("extended frame passed standard-only filter");

  property p_fmt_ignored;
    @(posedge hclk) disable iff (!hresetn)
    (!mask_en_r && filt_r[15:5] == msg_r[28:18] && filt_r[1:0] == msg_r[17:16])
      |=> filter_hit;
  endproperty
  a_fmt_ignored: assert property (p_fmt_ignored)
    else $error("format blocked match with mask enable off");

  property p_ext_mismatch;
    @(posedge hclk) disable iff (!hresetn)
    (filt_r[1:0] != msg_r[17:16]) |=> !filter_hit;
  endproperty
  a_ext_mismatch: assert property (p_ext_mismatch)
    else $error("extended bit mismatch yet hit");

  property p_ext_zero;
    @(posedge hclk) disable iff (!hresetn)
    (filt_r[1:0] == 2'b00 && msg_r[17:16] != 2'b00) |=> !filter_hit;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("zero extended pattern matched nonzero");
endmodule : caf_filter
`default_nettype wire

// file: src/caf_map.svh
/*
  register offsets, field positions and reset values of the acceptance filter.
  assumes inclusion by bare name from the block's source files.
*/
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH

// ****************************************
// register map
// ****************************************
`define CAF_FILT_OFFS 8'h00
`define CAF_CTRL_OFFS 8'h04
`define CAF_MSG_ID_OFFS 8'h08
`define CAF_STAT_OFFS 8'h0C

// ****************************************
// filter register fields
// ****************************************
`define CAF_STD_HI 15
`define CAF_STD_LO 5
`define CAF_FMT_BIT 3
`define CAF_EXT_HI 1
`define CAF_EXT_LO 0
`define CAF_FILT_WMASK 16'hFFEB
`define CAF_FILT_RESET 16'h0000

// ****************************************
// received identifier register fields
// ****************************************
`define CAF_MSG_STD_HI 28
`define CAF_MSG_STD_LO 18
`define CAF_MSG_EXT_HI 17
`define CAF_MSG_EXT_LO 16
`define CAF_MSG_XTD_BIT 31

`endif

// file: src/caf_match.sv
/*
  combinational identifier comparator of one acceptance filter.
  assumes the filter pattern and received identifier are steady on hclk.
*/
`timescale 1ns/1ns
`default_nettype none
module caf_match (
  input wire caf_pkg::caf_std_t std_id_pattern,
  input wire caf_pkg::caf_ext_t ext_id_pattern,
  input wire logic id_format_select,
  input wire logic id_format_mask_enable,
  input wire caf_pkg::caf_std_t msg_std_id,
  input wire caf_pkg::caf_ext_t msg_ext_id,
  input wire logic msg_is_ext,
  output logic hit
);
  import caf_pkg::*;
  logic [12:0] bit_eq;
  logic fmt_ok;

  // ****************************************
  // per-bit compare
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_eq
      if (gi < 11) begin : g_std
        assign bit_eq[gi] = (std_id_pattern[gi] == msg_std_id[gi]);
      end else begin : g_ext
        assign bit_eq[gi] = (ext_id_pattern[gi-11] == msg_ext_id[gi-11]);
      end
    end
  endgenerate

  always_comb begin
    fmt_ok = !id_format_mask_enable || (id_format_select == msg_is_ext);
    hit = fmt_ok && (&bit_eq);
  end
endmodule : caf_match
`default_nettype wire

// file: src/caf_pkg.sv
/*
  types shared by the acceptance filter block.
  assumes nothing of its surroundings.
*/
`default_nettype none
package caf_pkg;
  typedef logic [15:0] caf_filt_t;
  typedef logic [10:0] caf_std_t;
  typedef logic [1:0] caf_ext_t;
  typedef enum logic [1:0] {
    CAF_IDLE = 2'b01,
    CAF_DATA = 2'b10
  } caf_phase_e;
endpackage : caf_pkg
`default_nettype wire

// file: tb/testbench.sv
/*
  self-checking bench of the acceptance filter: AHB-Lite register access and match result.
  assumes caf_filter is the only slave, with hready looped back from hreadyout.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic filter_hit;
  logic [31:0] rd;
  logic [31:0] lfsr_r = 32'h0001_7161;
  logic [31:0] m;
  int fail_count = 0;
  int tests_run = 0;

  always #5 hclk = ~hclk;

  caf_filter u_caf_filter (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .filter_hit(filter_hit)
  );

  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic exp_hit(input logic [15:0] f, input logic me, input logic [31:0] m);
    return (f[15:5] == m[28:18]) && (f[1:0] == m[17:16]) && (!me || (f[3] == m[31]));
  endfunction : exp_hit

  // ****************************************
  // bus and compare tasks
  // ****************************************
  // the slave has no error path, so anything but OKAY is a fault
  task automatic chk_resp(input logic got);
    tests_run++;
    if (got !== 1'b0) begin
      fail_count++;
      $display("Error at %0t: bus response %b, expected OKAY", $time, got);
    end
  endtask : chk_resp

  // entered just after a rising edge; waits for hready at both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk_resp(hresp);
  endtask : ahb

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_hit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: match output %b, expected %b", $time, got, exp);
    end
  endtask : chk_hit

  // program filter, mask enable and message, then check output and status
  task automatic run_case(input logic [15:0] f, input logic me, input logic [31:0] msg);
    logic [31:0] r;
    logic e;
    e = exp_hit(f, me, msg);
    ahb(1'b1, 32'h00, {16'h0, f}, r);
    ahb(1'b1, 32'h04, {31'h0, me}, r);
    ahb(1'b1, 32'h08, msg, r);
    repeat (2) @(posedge hclk);
    chk_hit(filter_hit, e);
    ahb(1'b0, 32'h0C, 32'h0, r);
    chk_reg(r, {31'h0, e});
  endtask : run_case

  task automatic end_sim;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'h00, 32'h0, rd);
    chk_reg(rd, 32'h0000_0000);
    ahb(1'b1, 32'h00, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h00, 32'h0, rd);
    chk_reg(rd, 32'h0000_FFEB);
    ahb(1'b1, 32'h04, 32'hFFFF_FFFF, rd);
    ahb(1'b0, 32'h04, 32'h0, rd);
    chk_reg(rd, 32'h0000_0001);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk_reg(rd, 32'h0000_0000);
    $display("test registers done");
    // every combination of format select, mask enable and frame format
    for (int i = 0; i < 8; i++) begin
      run_case({11'h5A3, 1'b0, i[0], 3'b010}, i[1], {i[2], 2'b00, 11'h5A3, 2'b10, 16'h0});
    end
    $display("test format combinations done");
    // random patterns; some messages get one identifier bit flipped
    for (int i = 0; i < 40; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      m = {lfsr_r[31], 2'b00, lfsr_r[15:5], lfsr_r[1:0], 16'h0};
      if (lfsr_r[20]) begin
        m[16 + (lfsr_r[27:24] % 13)] = ~m[16 + (lfsr_r[27:24] % 13)];
      end
      run_case(lfsr_r[15:0], lfsr_r[16], m);
    end
    $display("test random patterns done");
    end_sim();
  end

  initial begin
    #100000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
